// ===== common/cgc_consts.svh
`ifndef CGC_CONSTS_SVH
`define CGC_CONSTS_SVH

// ****************************************
// Register offsets (byte addresses on the serial control port)
// ****************************************
`define CGC_ADDR_CHIP_CFG      15'h0002
`define CGC_ADDR_DEVICE_CLASS  15'h0003
`define CGC_ADDR_IDENT_LOW     15'h0004
`define CGC_ADDR_IDENT_HIGH    15'h0005
`define CGC_ADDR_SPEED_GRADE   15'h0006
`define CGC_ADDR_SCRATCH       15'h000a
`define CGC_ADDR_PORT_REV      15'h000b
`define CGC_ADDR_MAKER_LOW     15'h000c
`define CGC_ADDR_MAKER_HIGH    15'h000d
`define CGC_ADDR_TRIGGER       15'h000f

// ****************************************
// Field positions
// ****************************************
`define CGC_PMODE_LSB          0
`define CGC_PMODE_MSB          1
`define CGC_TRIG_BIT           0
`define CGC_GRADE_LSB          4
`define CGC_GRADE_MSB          7

// ****************************************
// Reset values and power mode codes
// ****************************************
`define CGC_RST_PMODE          2'h0
`define CGC_RST_SCRATCH        8'h00
`define CGC_PMODE_NORMAL       2'h0
`define CGC_PMODE_STANDBY      2'h2
`define CGC_PMODE_POWERDOWN    2'h3

// ****************************************
// Fixed read-only values (identity values arbitrary)
// ****************************************
`define CGC_VAL_DEVICE_CLASS   8'h7a
`define CGC_VAL_IDENT_LOW      8'h5b
`define CGC_VAL_IDENT_HIGH     8'h2c
`define CGC_VAL_GRADE          4'h9
`define CGC_VAL_PORT_REV       8'h3e
`define CGC_VAL_MAKER_LOW      8'h6d
`define CGC_VAL_MAKER_HIGH     8'h4f

// ****************************************
// Timing counts
// ****************************************
`define CGC_COPY_CYCLES        3'h4

`endif

// ===== common/cgc_pkg.sv
`default_nettype none

package cgc_pkg;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [14:0] addr;
		logic [7:0]  wdata;
	} cgc_req_t;

	typedef struct packed {
		logic datapath_clk_en;
		logic datapath_rst;
		logic link_en;
	} cgc_power_t;

	typedef enum logic [1:0] {
		CGC_IDLE,
		CGC_COPY,
		CGC_DONE
	} cgc_xfer_state_t;

endpackage

`default_nettype wire

// ===== core/cgc_global_regs.sv
// What this block does
// - Two-bit power mode, resets to normal
// - Mode 10 stops datapath clocks, link on
// - Mode 11 gates clocks, resets datapath, link off
// - Eight-bit scratch pad reads back writes
// - Transfer copies mixer settings if update mode
// - All mixer channels update together
// - Transfer also loads filter coefficients
// - Writing zero does nothing; idle reads zero
// - Bit self-clears only after copy finishes
`timescale 1ns/1ps
`default_nettype none
`include "cgc_consts.svh"

module cgc_global_regs
	import cgc_pkg::*;
(
	// Clock and reset
	input  wire logic      i_clk,
	input  wire logic      i_rstn,
	// Register access from the serial control port
	input  wire cgc_req_t  i_req,
	output logic [7:0]     o_rdata,
	output logic           o_rvalid,
	// Phase update mode bit from the down_converter bank
	input  wire logic      i_phase_update_mode,
	// Power control
	output cgc_power_t     o_power,
	// Staging to active copy strobes
	output logic           o_mixer_copy,
	output logic           o_filter_copy
);

	// ****************************************
	// Storage
	// ****************************************
	logic [1:0] power_mode;
	logic [7:0] scratch;
	logic       trig_pend;
	logic       start;
	logic       seq_busy;
	logic       seq_mixer;
	logic       seq_filter;
	logic       wr_trig;

	assign wr_trig = i_req.wr && (i_req.addr == `CGC_ADDR_TRIGGER)
	                 && i_req.wdata[`CGC_TRIG_BIT];

	// ****************************************
	// Power mode register
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			power_mode <= `CGC_RST_PMODE;
		end else if (i_req.wr && i_req.addr == `CGC_ADDR_CHIP_CFG) begin
			power_mode <= i_req.wdata[`CGC_PMODE_MSB:`CGC_PMODE_LSB];
		end
	end

	// Code 01 is undefined; treated as normal so the chip stays usable
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_power <= '{datapath_clk_en: 1'b1, datapath_rst: 1'b0, link_en: 1'b1};
		end else begin
			case (power_mode)
				`CGC_PMODE_STANDBY: o_power <= '{datapath_clk_en: 1'b0, datapath_rst: 1'b0,
				                                 link_en: 1'b1};
				`CGC_PMODE_POWERDOWN: o_power <= '{datapath_clk_en: 1'b0, datapath_rst: 1'b1,
				                                   link_en: 1'b0};
				default: o_power <= '{datapath_clk_en: 1'b1, datapath_rst: 1'b0, link_en: 1'b1};
			endcase
		end
	end

	// ****************************************
	// Scratch pad
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			scratch <= `CGC_RST_SCRATCH;
		end else if (i_req.wr && i_req.addr == `CGC_ADDR_SCRATCH) begin
			scratch <= i_req.wdata;
		end
	end

	// ****************************************
	// Transfer bit
	// ****************************************
	// A new request during a copy is ignored; the bit already reads one
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			trig_pend <= 1'b0;
			start     <= 1'b0;
		end else begin
			start <= wr_trig && !trig_pend;
			if (wr_trig) begin
				trig_pend <= 1'b1;
			end else if (trig_pend && !start && !seq_busy) begin
				trig_pend <= 1'b0;
			end
		end
	end

	cgc_xfer_seq u_seq (
		.i_clk               (i_clk),
		.i_rstn              (i_rstn),
		.i_start             (start),
		.i_phase_update_mode (i_phase_update_mode),
		.o_mixer_copy        (seq_mixer),
		.o_filter_copy       (seq_filter),
		.o_busy              (seq_busy)
	);

	// One shared strobe feeds every channel, so all mixers switch together
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_mixer_copy  <= 1'b0;
			o_filter_copy <= 1'b0;
		end else begin
			o_mixer_copy  <= seq_mixer;
			o_filter_copy <= seq_filter;
		end
	end

	// ****************************************
	// Read port
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_rdata  <= 8'h00;
			o_rvalid <= 1'b0;
		end else begin
			o_rvalid <= i_req.rd;
			if (!i_req.rd) begin
				o_rdata <= o_rdata;
			end else if (i_req.addr == `CGC_ADDR_CHIP_CFG) begin
				o_rdata <= {6'h00, power_mode};
			end else if (i_req.addr == `CGC_ADDR_DEVICE_CLASS) begin
				o_rdata <= `CGC_VAL_DEVICE_CLASS;
			end else if (i_req.addr == `CGC_ADDR_IDENT_LOW) begin
				o_rdata <= `CGC_VAL_IDENT_LOW;
			end else if (i_req.addr == `CGC_ADDR_IDENT_HIGH) begin
				o_rdata <= `CGC_VAL_IDENT_HIGH;
			end else if (i_req.addr == `CGC_ADDR_SPEED_GRADE) begin
				o_rdata <= {`CGC_VAL_GRADE, 4'h0};
			end else if (i_req.addr == `CGC_ADDR_SCRATCH) begin
				o_rdata <= scratch;
			end else if (i_req.addr == `CGC_ADDR_PORT_REV) begin
				o_rdata <= `CGC_VAL_PORT_REV;
			end else if (i_req.addr == `CGC_ADDR_MAKER_LOW) begin
				o_rdata <= `CGC_VAL_MAKER_LOW;
			end else if (i_req.addr == `CGC_ADDR_MAKER_HIGH) begin
				o_rdata <= `CGC_VAL_MAKER_HIGH;
			end else if (i_req.addr == `CGC_ADDR_TRIGGER) begin
				o_rdata <= {7'h00, trig_pend};
			end else begin
				o_rdata <= 8'h00;
			end
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	a_pmode_standby: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(power_mode == `CGC_PMODE_STANDBY) |=> (!o_power.datapath_clk_en && o_power.link_en))
		else $error("standby outputs wrong");

	a_pmode_down: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(power_mode == `CGC_PMODE_POWERDOWN)
		|=> (!o_power.datapath_clk_en && o_power.datapath_rst && !o_power.link_en))
		else $error("power-down outputs wrong");

	a_pmode_normal: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(power_mode == `CGC_PMODE_NORMAL) |=> (o_power.datapath_clk_en && !o_power.datapath_rst))
		else $error("normal mode outputs wrong");

	a_scratch_echo: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(i_req.wr && i_req.addr == `CGC_ADDR_SCRATCH) ##1 (i_req.rd && !i_req.wr && i_req.addr == `CGC_ADDR_SCRATCH)
		|=> (o_rdata == $past(i_req.wdata, 2)))
		else $error("scratch readback mismatch");

	a_trig_write_zero: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(!trig_pend && !wr_trig) |=> !trig_pend)
		else $error("transfer bit set without a one written");

	a_trig_start_copy: assert property (@(posedge i_clk) disable iff (!i_rstn)
		$rose(trig_pend) |-> ##[2:3] o_filter_copy)
		else $error("filter copy not started");

	a_mixer_gated: assert property (@(posedge i_clk) disable iff (!i_rstn)
		$rose(o_mixer_copy) |-> $past(i_phase_update_mode, 2))
		else $error("mixer copy without update mode");

	a_mixer_follows_mode: assert property (@(posedge i_clk) disable iff (!i_rstn)
		$rose(o_filter_copy) |-> (o_mixer_copy == $past(i_phase_update_mode, 2)))
		else $error("mixer copy does not follow update mode");

	a_mixer_with_filter: assert property (@(posedge i_clk) disable iff (!i_rstn)
		o_mixer_copy |-> o_filter_copy)
		else $error("mixer copy outside shared window");

	a_clear_after_copy: assert property (@(posedge i_clk) disable iff (!i_rstn)
		$fell(trig_pend) |-> (!o_filter_copy && !seq_busy))
		else $error("transfer bit cleared before copy done");

	a_ident_fixed: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(i_req.rd && i_req.addr == `CGC_ADDR_DEVICE_CLASS) |=> (o_rdata == `CGC_VAL_DEVICE_CLASS))
		else $error("device class changed");

endmodule // cgc_global_regs

`default_nettype wire

// ===== core/cgc_xfer_seq.sv
`timescale 1ns/1ps
`default_nettype none
`include "cgc_consts.svh"

module cgc_xfer_seq
	import cgc_pkg::*;
(
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_rstn,
	// Control
	input  wire logic i_start,
	input  wire logic i_phase_update_mode,
	// Copy strobes and busy flag
	output logic      o_mixer_copy,
	output logic      o_filter_copy,
	output logic      o_busy
);

	cgc_xfer_state_t state;
	logic [2:0]      count;

	// ****************************************
	// Sequencer
	// ****************************************
	// Copy strobes held for a fixed window so slow staging logic settles
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			state         <= CGC_IDLE;
			count         <= 3'h0;
			o_mixer_copy  <= 1'b0;
			o_filter_copy <= 1'b0;
			o_busy        <= 1'b0;
		end else begin
			case (state)
				CGC_IDLE: begin
					if (i_start) begin
						state         <= CGC_COPY;
						count         <= `CGC_COPY_CYCLES;
						o_busy        <= 1'b1;
						o_mixer_copy  <= i_phase_update_mode;
						o_filter_copy <= 1'b1;
					end
				end
				CGC_COPY: begin
					count <= count - 3'h1;
					if (count == 3'h1) begin
						state         <= CGC_DONE;
						o_mixer_copy  <= 1'b0;
						o_filter_copy <= 1'b0;
					end
				end
				default: begin
					state  <= CGC_IDLE;
					o_busy <= 1'b0;
				end
			endcase
		end
	end

	a_copy_ends_busy: assert property (@(posedge i_clk) disable iff (!i_rstn)
		$fell(o_filter_copy) |-> ##1 !o_busy)
		else $error("busy did not drop after copy");

endmodule // cgc_xfer_seq

`default_nettype wire

// ===== test/cgc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "cgc_consts.svh"

module cgc_host_model
	import cgc_pkg::*;
(
	// Clock
	input  wire logic       i_clk,
	// Device answer
	input  wire logic [7:0] i_rdata,
	input  wire logic       i_rvalid,
	// Requests
	output var  cgc_req_t   o_req
);
	initial o_req = '0;

	// Released lines carry the inverse of the last value, so a stale match cannot pass
	task automatic write_reg(input logic [14:0] a, input logic [7:0] d);
		@(negedge i_clk);
		o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge i_clk);
		o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask

	task automatic read_reg(input logic [14:0] a, output logic [7:0] d);
		@(negedge i_clk);
		o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~o_req.wdata};
		@(negedge i_clk);
		d = (i_rvalid === 1'b1) ? i_rdata : 8'hxx;
		o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~o_req.wdata};
	endtask

	// Write then read back in the very next cycle, no idle gap between them
	task automatic write_read(input logic [14:0] a, input logic [7:0] v, output logic [7:0] d);
		@(negedge i_clk);
		o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		@(negedge i_clk);
		o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~v};
		@(negedge i_clk);
		d = (i_rvalid === 1'b1) ? i_rdata : 8'hxx;
		o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: v};
	endtask

	// Bounded poll, so a bit that never clears cannot hang the host
	task automatic wait_xfer(output int polls);
		logic [7:0] d;
		polls = 0;
		do begin
			read_reg(`CGC_ADDR_TRIGGER, d);
			polls++;
		end while (d[0] !== 1'b0 && polls < 20);
	endtask
endmodule // cgc_host_model
`default_nettype wire

// ===== test/chip_global_config_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "cgc_consts.svh"

module chip_global_config_regs_tb_top
	import cgc_pkg::*;
;
	logic       i_clk;
	logic       i_rstn;
	logic       mode;
	cgc_req_t   req;
	logic [7:0] rdata;
	logic       rvalid;
	cgc_power_t pwr;
	logic       mix;
	logic       filt;
	logic [7:0] d;
	int         mismatches = 0;
	int         n_tests = 0;
	int         n_mix;
	int         n_filt;
	int         polls;

	cgc_global_regs dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_req(req), .o_rdata(rdata), .o_rvalid(rvalid),
		.i_phase_update_mode(mode), .o_power(pwr), .o_mixer_copy(mix), .o_filter_copy(filt));
	cgc_host_model host_u (.i_clk(i_clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_req(req));

	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	// Strobe cycles are counted on the edge the design updates them
	always @(posedge i_clk) begin
		n_mix += (mix === 1'b1);
		n_filt += (filt === 1'b1);
	end

	// ****************************************
	// Checking and closing
	// ****************************************
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic test_reset();
		check("power", {5'h0, pwr}, 8'h05);
		host_u.read_reg(`CGC_ADDR_CHIP_CFG, d);
		check("cfg", d, 8'h00);
		host_u.read_reg(`CGC_ADDR_SCRATCH, d);
		check("scratch", d, 8'h00);
		host_u.read_reg(`CGC_ADDR_TRIGGER, d);
		check("trigger", d, 8'h00);
	endtask

	// Read-only places and one unmapped address, each hit by a write first
	task automatic test_ids();
		logic [14:0] a[8] = '{`CGC_ADDR_DEVICE_CLASS, `CGC_ADDR_IDENT_LOW, `CGC_ADDR_IDENT_HIGH,
			`CGC_ADDR_SPEED_GRADE, `CGC_ADDR_PORT_REV, `CGC_ADDR_MAKER_LOW, `CGC_ADDR_MAKER_HIGH, 15'h0007};
		logic [7:0] e[8] = '{`CGC_VAL_DEVICE_CLASS, `CGC_VAL_IDENT_LOW, `CGC_VAL_IDENT_HIGH, {`CGC_VAL_GRADE, 4'h0},
			`CGC_VAL_PORT_REV, `CGC_VAL_MAKER_LOW, `CGC_VAL_MAKER_HIGH, 8'h00};
		foreach (a[i]) begin
			host_u.write_reg(a[i], ~e[i]);
			host_u.read_reg(a[i], d);
			check("ident", d, e[i]);
		end
	endtask

	task automatic test_scratch();
		logic [7:0] v[3] = '{8'ha5, 8'h5a, 8'hff};
		foreach (v[i]) begin
			host_u.write_read(`CGC_ADDR_SCRATCH, v[i], d);
			check("scratch", d, v[i]);
			check("power", {5'h0, pwr}, 8'h05);
		end
	endtask

	// Reserved bits are written as ones to prove they stay zero
	task automatic test_power();
		logic [2:0] e[4] = '{3'b101, 3'b101, 3'b001, 3'b010};
		for (int c = 0; c < 4; c++) begin
			host_u.write_reg(`CGC_ADDR_CHIP_CFG, {6'h3f, 2'(c)});
			host_u.read_reg(`CGC_ADDR_CHIP_CFG, d);
			check("cfg", d, {6'h0, 2'(c)});
			check("power", {5'h0, pwr}, {5'h0, e[c]});
		end
		host_u.write_reg(`CGC_ADDR_CHIP_CFG, 8'h00);
	endtask

	// A second start while pending must not add strobe cycles
	task automatic test_xfer(input logic m);
		mode = m;
		n_mix = 0;
		n_filt = 0;
		host_u.write_reg(`CGC_ADDR_TRIGGER, 8'h01);
		host_u.write_reg(`CGC_ADDR_TRIGGER, 8'hff);
		host_u.read_reg(`CGC_ADDR_TRIGGER, d);
		check("pending", d, 8'h01);
		host_u.wait_xfer(polls);
		check("polls", 8'(polls < 20), 8'h01);
		check("filter", 8'(n_filt), 8'h04);
		check("mixer", 8'(n_mix), m ? 8'h04 : 8'h00);
		repeat (10) @(negedge i_clk);
		check("filter", 8'(n_filt), 8'h04);
		check("mixer", 8'(n_mix), m ? 8'h04 : 8'h00);
	endtask

	task automatic test_zero();
		n_filt = 0;
		host_u.write_reg(`CGC_ADDR_TRIGGER, 8'hfe);
		repeat (10) @(negedge i_clk);
		check("filter", 8'(n_filt), 8'h00);
		host_u.read_reg(`CGC_ADDR_TRIGGER, d);
		check("trigger", d, 8'h00);
	endtask

	initial begin
		i_rstn = 1'b0;
		mode = 1'b0;
		repeat (12) @(negedge i_clk);
		i_rstn = 1'b1;
		test_reset();
		test_ids();
		test_scratch();
		test_power();
		test_xfer(1'b1);
		test_xfer(1'b0);
		test_zero();
		print_verdict();
	end

	// Whole run needs well under 1000 cycles
	initial begin
		#(8 * 5000);
		mismatches++;
		print_verdict();
	end
endmodule // chip_global_config_regs_tb_top
`default_nettype wire
